// ### hw/unlock_map.svh
// offsets, field codes and reset values of the unlock and set-features block
// included by the design modules, not by the package; definitions only
`ifndef UNLOCK_MAP_SVH
`define UNLOCK_MAP_SVH

`define A_CMD        12'h000
`define A_STAT       12'h004
`define A_DATA       12'h008
`define A_RESULT     12'h00c
`define A_MODE       12'h010
`define A_SECCFG     12'h014
`define A_UPW_PAGE   6'h01
`define A_MPW_PAGE   6'h02

`define OP_UNLOCK    8'hf2
`define OP_ERASE     8'hf4
`define OP_SETFEAT   8'hef

`define SF_8BIT_ON   8'h01
`define SF_8BIT_OFF  8'h81
`define SF_WC_ON     8'h02
`define SF_WC_OFF    8'h82
`define SF_XFER      8'h03
`define SF_APM_ON    8'h05
`define SF_APM_OFF   8'h85
`define SF_XPWR_ON   8'h09
`define SF_XPWR_OFF  8'h89
`define SF_PL1_ON    8'h0a
`define SF_PL1_OFF   8'h8a
`define SF_RLA_OFF   8'h55
`define SF_RLA_ON    8'haa
`define SF_POR_OFF   8'h66
`define SF_POR_ON    8'hcc
`define SF_NOP_A     8'h69
`define SF_NOP_B     8'h96
`define SF_NOP_C     8'h97
`define SF_CURLIM    8'h9a
`define SF_LONG4     8'hbb

`define XT_PIO_DEF   5'h00
`define XT_PIO_FC    5'h01
`define XT_MDMA      5'h04
`define XT_UDMA      5'h08
`define MD_NO_IORDY  3'h1
`define MD_IORDY_REQ 3'h3
`define PIO_MAX      3'h4
`define MDMA_MAX     3'h2
`define UDMA_MAX     3'h4

`define APM_RSV_LO   8'h00
`define APM_RSV_HI   8'hff
`define APM_MAX_PERF 8'hfe
`define CUR_MIN      8'h05
`define CUR_MAX      8'h28

`define TRIES_RST    3'h5
`define WORD_LAST    8'hff

`endif

// ### hw/unlock_pkg.sv
// types of the unlock and set-features block
// does not include unlock_map.svh; the design modules include it
`default_nettype none
package unlock_pkg;

	typedef enum logic [1:0] {ST_IDLE, ST_SECTOR, ST_FLUSH} phase_t;

	// settings that a soft reset may restore
	typedef struct packed {
		logic       eight_bit;
		logic       iois16_ok;
		logic [2:0] pio_mode;
		logic       iordy_en;
		logic       dma_udma;
		logic [2:0] dma_mode;
		logic       wcache;
		logic       apm_en;
		logic [7:0] apm_level;
		logic       pl1_en;
		logic       lookahead;
		logic       por_soft;
		logic [7:0] cur_limit;
	} cfg_t;

	typedef struct packed {
		phase_t            phase;
		logic [7:0]        opcode;
		logic [7:0]        feat;
		logic [7:0]        count;
		logic [7:0]        word_idx;
		logic              ident;
		logic              mism;
		logic              err;
		logic              locked;
		logic              level_max;
		logic [2:0]        tries;
		cfg_t              cfg;
		logic              flush_req;
		logic [7:0]        cyl_lo;
		logic [7:0]        cyl_hi;
		logic              erase_req;
		logic              done;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
		logic [15:0][15:0] upw;
		logic [15:0][15:0] mpw;
	} core_state_t;

endpackage
`default_nettype wire

// ### hw/xfer_mode_decode.sv
// decodes the transfer-mode byte of set-features subcommand 03h
// purely combinational; caller registers the result
`timescale 1ns/100ps
`default_nettype none
`include "unlock_map.svh"
module xfer_mode_decode (
	input  wire logic [7:0] code_i,
	output logic            ok_o,
	output logic            pio_o,
	output logic            mdma_o,
	output logic            udma_o,
	output logic [2:0]      mode_o,
	output logic            no_iordy_o
);
	always_comb begin
		ok_o       = 1'b0;
		pio_o      = 1'b0;
		mdma_o     = 1'b0;
		udma_o     = 1'b0;
		mode_o     = code_i[2:0];
		no_iordy_o = 1'b0;
		case (code_i[7:3])
			`XT_PIO_DEF: begin
				ok_o       = code_i[2:0] <= `MD_NO_IORDY;
				pio_o      = 1'b1;
				mode_o     = 3'h0;
				no_iordy_o = code_i[2:0] == `MD_NO_IORDY;
			end
			`XT_PIO_FC: begin
				ok_o  = code_i[2:0] <= `PIO_MAX;
				pio_o = 1'b1;
			end
			`XT_MDMA: begin
				ok_o   = code_i[2:0] <= `MDMA_MAX;
				mdma_o = 1'b1;
			end
			`XT_UDMA: begin
				ok_o   = code_i[2:0] <= `UDMA_MAX;
				udma_o = 1'b1;
			end
			default: ok_o = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// ### hw/cur_clamp.sv
// clamps a requested current quarter-milliamp figure into the supported range
// purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "unlock_map.svh"
module cur_clamp (
	input  wire logic [7:0] req_i,
	output logic [7:0]      lim_o
);
	always_comb begin
		if (req_i < `CUR_MIN) begin
			lim_o = `CUR_MIN;
		end else if (req_i > `CUR_MAX) begin
			lim_o = `CUR_MAX;
		end else begin
			lim_o = req_i;
		end
	end
endmodule
`default_nettype wire

// ### hw/unlock_feature_ctrl.sv
// security unlock and set-features command logic with an apb register port
// assumes soft_rst_i and flush_done_i come from logic on clock_i
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "unlock_map.svh"
module unlock_feature_ctrl (
	input  wire logic        clock_i,
	input  wire logic        sys_rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        soft_rst_i,
	input  wire logic        flush_done_i,
	output logic             flush_req_o,
	output logic             cmd_done_o,
	output logic             erase_req_o,
	output logic             eight_bit_o,
	output logic             iois16_ok_o,
	output logic [2:0]       pio_mode_o,
	output logic             iordy_en_o,
	output logic             dma_udma_o,
	output logic [2:0]       dma_mode_o,
	output logic             wcache_en_o,
	output logic             apm_en_o,
	output logic [7:0]       apm_level_o,
	output logic             pl1_en_o,
	output logic             lookahead_o,
	output logic [7:0]       cur_limit_o
);
	localparam unlock_pkg::cfg_t CFG_RST = '{
		iois16_ok: 1'b1, iordy_en: 1'b1, apm_level: `APM_MAX_PERF,
		por_soft: 1'b1, cur_limit: `CUR_MAX, default: '0};
	localparam unlock_pkg::core_state_t ST_RST = '{
		phase: unlock_pkg::ST_IDLE, tries: `TRIES_RST, cfg: CFG_RST, default: '0};

	unlock_pkg::core_state_t st_r;
	unlock_pkg::core_state_t st_nxt;

	logic        busy;
	logic        acc;
	logic        refuse;
	logic [31:0] rdat;
	logic        wr;
	logic        dwr;
	logic        cwr;
	logic        evl;
	logic [3:0]  pidx;
	logic [15:0] pw_ref;
	logic        xm_ok;
	logic        xm_pio;
	logic        xm_mdma;
	logic        xm_udma;
	logic [2:0]  xm_mode;
	logic        xm_no_iordy;
	logic [7:0]  clamped;
	logic        sf_exec;

	// fed from the bus word, not st_nxt, so the decode does not loop back into st_nxt
	xfer_mode_decode u_xfer (
		.code_i     (pwdata_i[23:16]),
		.ok_o       (xm_ok),
		.pio_o      (xm_pio),
		.mdma_o     (xm_mdma),
		.udma_o     (xm_udma),
		.mode_o     (xm_mode),
		.no_iordy_o (xm_no_iordy)
	);

	cur_clamp u_clamp (
		.req_i (pwdata_i[23:16]),
		.lim_o (clamped)
	);

	always_comb begin
		st_nxt         = st_r;
		st_nxt.done      = 1'b0;
		st_nxt.erase_req = 1'b0;
		busy   = st_r.phase != unlock_pkg::ST_IDLE;
		acc    = psel_i & penable_i;
		rdat   = '0;
		refuse = 1'b0;
		sf_exec = 1'b0;
		// software passwords are write-only so the secret never reads back
		if (paddr_i == `A_CMD) begin
			rdat   = {8'h00, st_r.count, st_r.feat, st_r.opcode};
			refuse = pwrite_i & busy;
		end else if (paddr_i == `A_STAT) begin
			rdat = {23'h000000, st_r.level_max, st_r.tries, st_r.tries == 3'h0,
				st_r.locked, st_r.err, st_r.phase == unlock_pkg::ST_SECTOR, busy};
		end else if (paddr_i == `A_DATA) begin
			rdat   = {24'h000000, st_r.word_idx};
			refuse = pwrite_i & (st_r.phase != unlock_pkg::ST_SECTOR);
		end else if (paddr_i == `A_RESULT) begin
			rdat = {16'h0000, st_r.cyl_hi, st_r.cyl_lo};
		end else if (paddr_i == `A_MODE) begin
			rdat = {1'b0, st_r.cfg};
		end else if (paddr_i == `A_SECCFG) begin
			rdat   = {30'h00000000, st_r.level_max, st_r.locked};
			refuse = pwrite_i & busy;
		end else if (paddr_i[11:6] == `A_UPW_PAGE || paddr_i[11:6] == `A_MPW_PAGE) begin
			refuse = pwrite_i & busy;
		end else begin
			refuse = 1'b1;
		end
		// one wait state: answer is prepared in the first access cycle
		st_nxt.pready  = acc & ~st_r.pready;
		st_nxt.pslverr = acc & ~st_r.pready & refuse;
		st_nxt.prdata  = (acc & ~st_r.pready & ~pwrite_i & ~refuse) ? rdat : 32'h00000000;
		wr  = acc & st_r.pready & pwrite_i & ~st_r.pslverr;
		dwr = wr & (paddr_i == `A_DATA);
		cwr = wr & (paddr_i == `A_CMD);
		evl = dwr & (st_r.word_idx == `WORD_LAST);
		pidx   = st_r.word_idx[3:0] - 4'h1;
		pw_ref = st_r.ident ? st_r.mpw[pidx] : st_r.upw[pidx];

		if (wr & (paddr_i == `A_SECCFG)) begin
			st_nxt.locked    = pwdata_i[0];
			st_nxt.level_max = pwdata_i[1];
		end
		if (wr & (paddr_i[11:6] == `A_UPW_PAGE)) begin
			st_nxt.upw[paddr_i[5:2]] = pwdata_i[15:0];
		end
		if (wr & (paddr_i[11:6] == `A_MPW_PAGE)) begin
			st_nxt.mpw[paddr_i[5:2]] = pwdata_i[15:0];
		end

		if (cwr) begin
			st_nxt.opcode = pwdata_i[7:0];
			st_nxt.feat   = pwdata_i[15:8];
			st_nxt.count  = pwdata_i[23:16];
			st_nxt.err    = 1'b0;
			if (pwdata_i[7:0] == `OP_UNLOCK) begin
				st_nxt.phase    = unlock_pkg::ST_SECTOR;
				st_nxt.word_idx = 8'h00;
				st_nxt.mism     = 1'b0;
			end else if (pwdata_i[7:0] == `OP_SETFEAT) begin
				sf_exec = 1'b1;
			end else if (pwdata_i[7:0] == `OP_ERASE) begin
				st_nxt.err       = st_r.tries == 3'h0;
				st_nxt.erase_req = st_r.tries != 3'h0;
				st_nxt.done      = 1'b1;
			end else begin
				st_nxt.err  = 1'b1;
				st_nxt.done = 1'b1;
			end
		end

		if (dwr) begin
			st_nxt.word_idx = st_r.word_idx + 8'h01;
			if (st_r.word_idx == 8'h00) begin
				st_nxt.ident = pwdata_i[0];
			end else if (st_r.word_idx <= 8'h10) begin
				st_nxt.mism = st_r.mism | (pwdata_i[15:0] != pw_ref);
			end
		end
		if (evl) begin
			st_nxt.phase = unlock_pkg::ST_IDLE;
			st_nxt.done  = 1'b1;
			if (st_r.tries == 3'h0) begin
				st_nxt.err = 1'b1;
			end else if (st_r.ident & st_r.level_max) begin
				st_nxt.err = 1'b1;
			end else if (st_r.mism) begin
				st_nxt.err = 1'b1;
				if (st_r.locked) begin
					st_nxt.tries = st_r.tries - 3'h1;
				end
			end else begin
				st_nxt.locked = 1'b0;
			end
		end

		if (sf_exec) begin
			st_nxt.done = 1'b1;
			case (st_nxt.feat)
				`SF_8BIT_ON: begin
					st_nxt.cfg.eight_bit = 1'b1;
					st_nxt.cfg.iois16_ok = 1'b0;
				end
				`SF_8BIT_OFF: begin
					st_nxt.cfg.eight_bit = 1'b0;
					st_nxt.cfg.iois16_ok = 1'b1;
				end
				`SF_WC_ON: st_nxt.cfg.wcache = 1'b1;
				`SF_WC_OFF: begin
					st_nxt.cfg.wcache = 1'b0;
					// if the cache was on, completion waits for the flush acknowledge
					if (st_r.cfg.wcache) begin
						st_nxt.phase     = unlock_pkg::ST_FLUSH;
						st_nxt.flush_req = 1'b1;
						st_nxt.done      = 1'b0;
					end
				end
				`SF_XFER: begin
					if (!xm_ok) begin
						st_nxt.err = 1'b1;
					end else if (xm_pio) begin
						st_nxt.cfg.pio_mode = xm_mode;
						st_nxt.cfg.iordy_en = ~xm_no_iordy | (xm_mode >= `MD_IORDY_REQ);
					end else begin
						st_nxt.cfg.dma_udma = xm_udma;
						st_nxt.cfg.dma_mode = xm_mode;
					end
				end
				`SF_APM_ON: begin
					if (st_nxt.count == `APM_RSV_LO || st_nxt.count == `APM_RSV_HI) begin
						st_nxt.err = 1'b1;
					end else begin
						st_nxt.cfg.apm_en    = 1'b1;
						st_nxt.cfg.apm_level = st_nxt.count;
					end
				end
				`SF_APM_OFF: st_nxt.cfg.apm_en = 1'b0;
				`SF_PL1_ON: st_nxt.cfg.pl1_en = 1'b1;
				`SF_PL1_OFF: st_nxt.cfg.pl1_en = 1'b0;
				`SF_RLA_OFF: st_nxt.cfg.lookahead = 1'b0;
				`SF_RLA_ON: st_nxt.cfg.lookahead = 1'b1;
				`SF_POR_OFF: st_nxt.cfg.por_soft = 1'b0;
				`SF_POR_ON: st_nxt.cfg.por_soft = 1'b1;
				`SF_CURLIM: begin
					st_nxt.cfg.cur_limit = clamped;
					st_nxt.cyl_lo        = `CUR_MIN;
					st_nxt.cyl_hi        = `CUR_MAX;
				end
				`SF_XPWR_ON, `SF_XPWR_OFF, `SF_NOP_A, `SF_NOP_B, `SF_NOP_C, `SF_LONG4: begin
					st_nxt.err = 1'b0;
				end
				default: st_nxt.err = 1'b1;
			endcase
		end

		case (st_r.phase)
			unlock_pkg::ST_FLUSH: begin
				if (flush_done_i) begin
					st_nxt.phase     = unlock_pkg::ST_IDLE;
					st_nxt.flush_req = 1'b0;
					st_nxt.done      = 1'b1;
				end
			end
			unlock_pkg::ST_IDLE, unlock_pkg::ST_SECTOR: st_nxt.flush_req = st_nxt.flush_req;
			default: st_nxt.phase = unlock_pkg::ST_IDLE;
		endcase

		// soft reset drops any command in flight; the attempt counter survives
		if (soft_rst_i) begin
			st_nxt.phase     = unlock_pkg::ST_IDLE;
			st_nxt.flush_req = 1'b0;
			st_nxt.done      = 1'b0;
			if (st_r.cfg.por_soft) begin
				st_nxt.cfg = CFG_RST;
			end
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata_o    = st_r.prdata;
	assign pready_o    = st_r.pready;
	assign pslverr_o   = st_r.pslverr;
	assign flush_req_o = st_r.flush_req;
	assign cmd_done_o  = st_r.done;
	assign erase_req_o = st_r.erase_req;
	assign eight_bit_o = st_r.cfg.eight_bit;
	assign iois16_ok_o = st_r.cfg.iois16_ok;
	assign pio_mode_o  = st_r.cfg.pio_mode;
	assign iordy_en_o  = st_r.cfg.iordy_en;
	assign dma_udma_o  = st_r.cfg.dma_udma;
	assign dma_mode_o  = st_r.cfg.dma_mode;
	assign wcache_en_o = st_r.cfg.wcache;
	assign apm_en_o    = st_r.cfg.apm_en;
	assign apm_level_o = st_r.cfg.apm_level;
	assign pl1_en_o    = st_r.cfg.pl1_en;
	assign lookahead_o = st_r.cfg.lookahead;
	assign cur_limit_o = st_r.cfg.cur_limit;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);

	AST_TRIES_NEVER_RISE: assert property (1'b1 |=> st_r.tries <= $past(st_r.tries))
		else $error("attempt counter rose without reset");
	AST_LOCKOUT_ABORTS: assert property (evl && st_r.tries == 3'h0 |=> cmd_done_o && st_r.err && st_r.tries == 3'h0)
		else $error("unlock not aborted at zero attempts");
	AST_ERASE_LOCKOUT: assert property (cwr && pwdata_i[7:0] == `OP_ERASE && st_r.tries == 3'h0 && !soft_rst_i |=> st_r.err && !erase_req_o)
		else $error("erase passed while locked out");
	AST_UNLOCKED_KEEPS: assert property (evl && !st_r.locked |=> $stable(st_r.tries))
		else $error("counter moved while unlocked");
	AST_MISMATCH_DEC: assert property (evl && st_r.mism && st_r.locked && st_r.tries != 3'h0 && !(st_r.ident && st_r.level_max) |=> st_r.err && st_r.tries == $past(st_r.tries) - 3'h1)
		else $error("mismatch did not abort and decrement");
	AST_MASTER_MAX: assert property (evl && st_r.ident && st_r.level_max |=> st_r.err && $stable(st_r.tries))
		else $error("master unlock at maximum level not rejected");
	AST_SECTOR_FIRST: assert property (st_r.phase == unlock_pkg::ST_SECTOR && !evl && !soft_rst_i |=> !cmd_done_o)
		else $error("unlock completed before full sector");
	AST_EIGHT_BIT: assert property (eight_bit_o |-> !iois16_ok_o)
		else $error("16-bit indication while in 8-bit mode");
	AST_IORDY_HIGH_PIO: assert property (pio_mode_o >= `MD_IORDY_REQ |-> iordy_en_o)
		else $error("iordy off in pio mode 3 or above");
	AST_DMA_EXCL: assert property (sf_exec && st_nxt.feat == `SF_XFER && xm_ok && !xm_pio && !soft_rst_i |=> dma_udma_o == $past(xm_udma))
		else $error("dma family not switched");
	AST_FLUSH_FIRST: assert property (flush_req_o && !flush_done_i && !soft_rst_i |=> !cmd_done_o && flush_req_o)
		else $error("completion before flush acknowledge");
	AST_CUR_RANGE: assert property (cur_limit_o >= `CUR_MIN && cur_limit_o <= `CUR_MAX)
		else $error("current limit out of range");
	AST_BAD_SUB_KEEPS: assert property (sf_exec && !xm_ok && st_nxt.feat == `SF_XFER && !soft_rst_i |=> st_r.err ##0 $stable(st_r.cfg))
		else $error("bad transfer mode changed settings");
endmodule
`default_nettype wire

// ### tb/flush_model.sv
// cache-side model: acknowledges a flush request after a programmable delay
// assumes the same clock and reset as the block
`timescale 1ns/100ps
`default_nettype none
module flush_model (
	input  wire logic       clock_i,
	input  wire logic       sys_rst_i,
	input  wire logic [7:0] delay_i,
	input  wire logic       flush_req_i,
	output logic            flush_done_o
);
	logic [7:0] wait_r;
	// one-cycle ack, so a stale level cannot close the next flush early
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wait_r <= 8'h00;
			flush_done_o <= 1'b0;
		end else begin
			flush_done_o <= flush_req_i && !flush_done_o && wait_r == delay_i;
			wait_r <= (flush_req_i && !flush_done_o) ? wait_r + 8'h01 : 8'h00;
		end
	end
endmodule
`default_nettype wire

// ### tb/security_unlock_and_feature_set_bench.sv
// self-checking bench for the unlock and set-features block with an apb master
// assumes flush_model on the cache side and one 200 MHz clock
`timescale 1ns/100ps
`default_nettype none
module security_unlock_and_feature_set_bench;
	logic        clock_i, sys_rst_i, psel, penable, pwrite, pready, pslverr, se;
	logic        soft_rst, fl_done, fl_req, done, erase, eight, io16, iordy;
	logic        udma, wc, apm, pl1, look;
	logic [2:0]  pio, dma;
	logic [7:0]  lvl, cur, fl_dly;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, st;
	int          miscompares, checks, done_n, erase_n, fl_n, cyc;

	unlock_feature_ctrl i_dut (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .soft_rst_i(soft_rst),
		.flush_done_i(fl_done), .flush_req_o(fl_req), .cmd_done_o(done),
		.erase_req_o(erase), .eight_bit_o(eight), .iois16_ok_o(io16), .pio_mode_o(pio),
		.iordy_en_o(iordy), .dma_udma_o(udma), .dma_mode_o(dma), .wcache_en_o(wc),
		.apm_en_o(apm), .apm_level_o(lvl), .pl1_en_o(pl1), .lookahead_o(look),
		.cur_limit_o(cur)
	);
	flush_model i_flush (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .delay_i(fl_dly),
		.flush_req_i(fl_req), .flush_done_o(fl_done)
	);

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	// edge counters let tasks wait on one-cycle pulses without racing them
	always @(posedge clock_i) begin
		cyc++;
		done_n += int'(done === 1'b1);
		erase_n += int'(erase === 1'b1);
		fl_n += int'(fl_req === 1'b1);
		if (cyc == 40000) begin
			miscompares++;
			final_report;
		end
	end

	task final_report;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		// ends on pready; with no limit of its own, only the bench timeout ends a wait that never sees it
		do begin
			@(posedge clock_i);
		end while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [15:0] pw(input int i);
		return 16'h3c00 + i[15:0];
	endfunction

	// issue a command; an unlock also sends its sector, msk spoils the password
	task run(input logic [7:0] op, ft, cnt, input logic [15:0] w0, msk);
		int i;
		int n;
		n = done_n;
		apb(1'b1, 12'h000, {8'h00, cnt, ft, op});
		for (i = 0; i < 256 && op == 8'hf2; i++)
			apb(1'b1, 12'h008, {16'h0, ((i == 0) ? w0 : (i < 17) ? pw(i - 1) ^ msk : 16'h0)});
		for (i = 0; i < 3000 && done_n == n; i++)
			@(posedge clock_i);
		chk(done_n - n, 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		st = rd;
	endtask

	task feat(input logic [7:0] ft, cnt, input logic e);
		run(8'hef, ft, cnt, 16'h0, 16'h0);
		chk({31'h0, st[2]}, {31'h0, e});
	endtask

	task pulse_soft;
		@(posedge clock_i);
		soft_rst <= 1'b1;
		@(posedge clock_i);
		soft_rst <= 1'b0;
		@(posedge clock_i);
	endtask

	task t_regs;
		apb(1'b0, 12'h010, 32'h0);
		chk(rd, 32'h2207f128);
		apb(1'b0, 12'h0f0, 32'h0);
		chk({31'h0, se}, 32'h1);
		apb(1'b1, 12'h008, 32'h0);
		chk({31'h0, se}, 32'h1);
		feat(8'h7e, 8'h00, 1'b1);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd, 32'h2207f128);
	endtask

	task t_feat;
		logic [7:0] nop [9];
		int i;
		nop = '{8'h09, 8'h89, 8'h69, 8'h96, 8'h97, 8'hbb, 8'h55, 8'haa, 8'h0a};
		feat(8'h01, 8'h00, 1'b0);
		chk({30'h0, eight, io16}, 32'h2);
		feat(8'h81, 8'h00, 1'b0);
		chk({30'h0, eight, io16}, 32'h1);
		feat(8'h05, 8'h80, 1'b0);
		feat(8'h05, 8'hff, 1'b1);
		chk({23'h0, apm, lvl}, 32'h180);
		feat(8'h85, 8'h00, 1'b0);
		chk({31'h0, apm}, 32'h0);
		feat(8'h9a, 8'h06, 1'b0);
		chk({24'h0, cur}, 32'h06);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h2805);
		feat(8'h9a, 8'h01, 1'b0);
		chk({24'h0, cur}, 32'h05);
		feat(8'h9a, 8'hff, 1'b0);
		chk({24'h0, cur}, 32'h28);
		for (i = 0; i < 9; i++)
			feat(nop[i], 8'h00, 1'b0);
		chk({30'h0, look, pl1}, 32'h3);
	endtask

	task t_xfer;
		logic [7:0] code [10];
		logic [8:0] want [10];
		int i;
		code = '{8'h0c, 8'h0b, 8'h22, 8'h44, 8'h23, 8'h10, 8'h22, 8'h01, 8'h02, 8'h00};
		want = '{9'h090, 9'h070, 9'h072, 9'h07c, 9'h17c, 9'h17c, 9'h072, 9'h002, 9'h102,
			9'h012};
		for (i = 0; i < 10; i++) begin
			run(8'hef, 8'h03, code[i], 16'h0, 16'h0);
			chk({23'h0, st[2], pio, iordy, udma, dma}, {23'h0, want[i]});
		end
	endtask

	task t_flush;
		int i;
		for (i = 0; i < 2; i++) begin
			fl_dly <= i ? 8'h28 : 8'h00;
			feat(8'h02, 8'h00, 1'b0);
			chk({31'h0, wc}, 32'h1);
			fl_n = 0;
			feat(8'h82, 8'h00, 1'b0);
			chk(fl_n, i ? 32'h2a : 32'h2);
			chk({31'h0, wc}, 32'h0);
		end
		fl_n = 0;
		feat(8'h82, 8'h00, 1'b0);
		chk(fl_n, 32'h0);
	endtask

	task t_soft;
		feat(8'h9a, 8'h06, 1'b0);
		pulse_soft;
		chk({23'h0, pl1, cur}, 32'h028);
		feat(8'h66, 8'h00, 1'b0);
		feat(8'h0a, 8'h00, 1'b0);
		pulse_soft;
		chk({31'h0, pl1}, 32'h1);
		feat(8'hcc, 8'h00, 1'b0);
		pulse_soft;
		chk({31'h0, pl1}, 32'h0);
	endtask

	task t_unlock;
		int i;
		for (i = 0; i < 16; i++) begin
			apb(1'b1, 12'h040 + 12'(4 * i), {16'h0, pw(i)});
			apb(1'b1, 12'h080 + 12'(4 * i), {16'h0, pw(i) ^ 16'h0f0f});
		end
		apb(1'b1, 12'h014, 32'h1);
		run(8'hf2, 8'h00, 8'h00, 16'h0000, 16'h0001);
		chk(st, 32'h08c);
		run(8'hf2, 8'h00, 8'h00, 16'hfffe, 16'h0000);
		chk(st, 32'h080);
		run(8'hf2, 8'h00, 8'h00, 16'h0000, 16'h0001);
		chk(st, 32'h084);
		apb(1'b1, 12'h014, 32'h3);
		run(8'hf2, 8'h00, 8'h00, 16'h0001, 16'h0f0f);
		chk(st, 32'h18c);
		apb(1'b1, 12'h014, 32'h1);
		run(8'hf2, 8'h00, 8'h00, 16'h0001, 16'h0000);
		chk(st, 32'h06c);
		run(8'hf2, 8'h00, 8'h00, 16'h0001, 16'h0f0f);
		chk(st, 32'h060);
		apb(1'b1, 12'h014, 32'h1);
		for (i = 0; i < 3; i++)
			run(8'hf2, 8'h00, 8'h00, 16'h0000, 16'h0001);
		chk(st, 32'h01c);
		run(8'hf2, 8'h00, 8'h00, 16'h0000, 16'h0000);
		chk(st, 32'h01c);
		i = erase_n;
		run(8'hf4, 8'h00, 8'h00, 16'h0, 16'h0);
		chk({st[2], 31'(erase_n - i)}, 32'h80000000);
		@(posedge clock_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0a0);
		i = erase_n;
		run(8'hf4, 8'h00, 8'h00, 16'h0, 16'h0);
		chk({st[2], 31'(erase_n - i)}, 32'h1);
	endtask

	initial begin
		sys_rst_i = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		soft_rst = 1'b0;
		fl_dly = 8'h00;
		repeat (2) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		t_regs;
		t_feat;
		t_xfer;
		t_flush;
		t_soft;
		t_unlock;
		final_report;
	end
endmodule
`default_nettype wire
